/* File: design/scgr_pkg.sv */
// package of constants and types for the sensor channel configuration bank
//
// Notes on behaviour
// - bit 7 of each channel register selects resistance range; 0 low, 1 high
// - bits 6-5 select frequency band; value 3 is reserved but stored
// - bits 4-0 hold the sensor cycle count setting the sampling window
// - channel registers reset to 04h: low range, lowest band, count 4
// - tracking register bits 2-1 hold channel 0 fast tracking factor
// - tracking register resets to DAh with reserved bits 1Bh and 0
// - every field of all four registers is readable and writable
package scgr_pkg;

    // ****************************************************************
    // register indices; byte address is four times the index
    // ****************************************************************
    localparam int unsigned SCGR_NUM_REGS = 4;
    localparam logic [7:0] SCGR_IDX_CHAN0_CFG = 8'h20;
    localparam logic [7:0] SCGR_IDX_CHAN1_CFG = 8'h22;
    localparam logic [7:0] SCGR_IDX_CHAN2_CFG = 8'h24;
    localparam logic [7:0] SCGR_IDX_CHAN0_TRK = 8'h25;

    // slot numbers inside the storage
    localparam logic [1:0] SCGR_SLOT_CHAN0_CFG = 2'h0;
    localparam logic [1:0] SCGR_SLOT_CHAN1_CFG = 2'h1;
    localparam logic [1:0] SCGR_SLOT_CHAN2_CFG = 2'h2;
    localparam logic [1:0] SCGR_SLOT_CHAN0_TRK = 2'h3;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] SCGR_RST_CHAN_CFG = 8'h04;
    localparam logic [7:0] SCGR_RST_CHAN0_TRK = 8'hda;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int unsigned SCGR_RANGE_BIT = 7;
    localparam int unsigned SCGR_BAND_MSB = 6;
    localparam int unsigned SCGR_BAND_LSB = 5;
    localparam int unsigned SCGR_COUNT_MSB = 4;
    localparam int unsigned SCGR_COUNT_LSB = 0;
    localparam int unsigned SCGR_TRK_RSVD_HI_MSB = 7;
    localparam int unsigned SCGR_TRK_RSVD_HI_LSB = 3;
    localparam int unsigned SCGR_TRK_FACTOR_MSB = 2;
    localparam int unsigned SCGR_TRK_FACTOR_LSB = 1;
    localparam int unsigned SCGR_TRK_RSVD_LO_BIT = 0;

    // ****************************************************************
    // bus answers
    // ****************************************************************
    localparam logic [1:0] SCGR_RESP_OKAY = 2'h0;
    localparam logic [1:0] SCGR_RESP_SLVERR = 2'h2;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        SCGR_BAND_1M_3M3,
        SCGR_BAND_3M3_10M,
        SCGR_BAND_10M_30M,
        SCGR_BAND_RESERVED
    } scgr_band_e;

    typedef struct packed {
        logic resistance_range;
        scgr_band_e frequency_band;
        logic [4:0] cycle_count;
    } scgr_chan_cfg_s;

    typedef struct packed {
        logic [4:0] reserved_hi;
        logic [1:0] fast_tracking_factor;
        logic reserved_lo;
    } scgr_tracking_s;

endpackage : scgr_pkg

/* File: design/scgr_reg_store.sv */
// storage for the configuration bytes with a registered read port
module scgr_reg_store #(
    parameter int unsigned NUM_REGS = scgr_pkg::SCGR_NUM_REGS
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic [1:0] wr_slot_i,
    input wire logic [7:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic rd_hit_i,
    input wire logic [1:0] rd_slot_i,
    output logic [7:0] rd_data_o,
    output logic [7:0] regs_o [NUM_REGS]
);
    import scgr_pkg::*;

    if (NUM_REGS != SCGR_NUM_REGS) begin : g_num_regs_check
        $error("scgr_reg_store serves exactly four registers");
    end

    logic [7:0] mem_reg [NUM_REGS];

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_reg[SCGR_SLOT_CHAN0_CFG] <= SCGR_RST_CHAN_CFG;
            mem_reg[SCGR_SLOT_CHAN1_CFG] <= SCGR_RST_CHAN_CFG;
            mem_reg[SCGR_SLOT_CHAN2_CFG] <= SCGR_RST_CHAN_CFG;
            mem_reg[SCGR_SLOT_CHAN0_TRK] <= SCGR_RST_CHAN0_TRK;
        end else if (wr_en_i) begin
            // all eight bits stored, reserved ones included
            mem_reg[wr_slot_i] <= wr_data_i;
        end
    end

    // unmapped reads return zero from the same flop
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_en_i) begin
            rd_data_o <= rd_hit_i ? mem_reg[rd_slot_i] : 8'h00;
        end
    end

    assign regs_o = mem_reg;

endmodule : scgr_reg_store

/* File: design/scgr_sensor_cfg.sv */
// axi4-lite slave holding channel sensor and tracking configuration
module scgr_sensor_cfg #(
    parameter int unsigned ADDR_W = 10
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // write address channel
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic [2:0] s_axi_awprot_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // write data channel
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // write response channel
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // read address channel
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic [2:0] s_axi_arprot_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    // read data channel
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // configuration towards the measurement core
    output scgr_pkg::scgr_chan_cfg_s chan0_sensor_config_o,
    output scgr_pkg::scgr_chan_cfg_s chan1_sensor_config_o,
    output scgr_pkg::scgr_chan_cfg_s chan2_sensor_config_o,
    output logic [1:0] chan0_fast_tracking_factor_o
);
    import scgr_pkg::*;

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // the highest byte address is 4 * 25h = 94h, so at least 8 bits
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_w_check
        $error("scgr_sensor_cfg needs ADDR_W between 8 and 32");
    end

    // ****************************************************************
    // address decode
    // ****************************************************************
    // returns {hit, slot}; the two low address bits are ignored so that
    // any byte inside an aligned word selects that word
    function automatic logic [2:0] decode_addr(
        input logic [ADDR_W-1:0] addr
    );
        logic [ADDR_W-3:0] word;
        logic [2:0] res;
        word = addr[ADDR_W-1:2];
        res = 3'h0;
        if (word == (ADDR_W-2)'(SCGR_IDX_CHAN0_CFG)) begin
            res = {1'b1, SCGR_SLOT_CHAN0_CFG};
        end else if (word == (ADDR_W-2)'(SCGR_IDX_CHAN1_CFG)) begin
            res = {1'b1, SCGR_SLOT_CHAN1_CFG};
        end else if (word == (ADDR_W-2)'(SCGR_IDX_CHAN2_CFG)) begin
            res = {1'b1, SCGR_SLOT_CHAN2_CFG};
        end else if (word == (ADDR_W-2)'(SCGR_IDX_CHAN0_TRK)) begin
            res = {1'b1, SCGR_SLOT_CHAN0_TRK};
        end
        return res;
    endfunction : decode_addr

    // ****************************************************************
    // write address and data capture
    // ****************************************************************
    logic aw_full_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic w_full_reg;
    logic [7:0] w_data_reg;
    logic w_lane0_reg;
    // ready flops hold the inverse of the full flags so each port leaves a flop
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic [2:0] wr_dec;
    logic wr_en;

    // address and data are taken in either order, each held until used
    assign aw_take = s_axi_awvalid_i && !aw_full_reg;
    assign w_take = s_axi_wvalid_i && !w_full_reg;
    // the write fires only once the previous response has been taken
    assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_dec = decode_addr(aw_addr_reg);
    // a cleared byte lane 0 leaves the register untouched
    assign wr_en = wr_fire && wr_dec[2] && w_lane0_reg;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_full_reg <= 1'b0;
            awready_reg <= 1'b1;
            aw_addr_reg <= '0;
        end else if (aw_take) begin
            aw_full_reg <= 1'b1;
            awready_reg <= 1'b0;
            aw_addr_reg <= s_axi_awaddr_i;
        end else if (wr_fire) begin
            aw_full_reg <= 1'b0;
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w_full_reg <= 1'b0;
            wready_reg <= 1'b1;
            w_data_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
        end else if (w_take) begin
            w_full_reg <= 1'b1;
            wready_reg <= 1'b0;
            w_data_reg <= s_axi_wdata_i[7:0];
            w_lane0_reg <= s_axi_wstrb_i[0];
        end else if (wr_fire) begin
            w_full_reg <= 1'b0;
            wready_reg <= 1'b1;
        end
    end

    // ****************************************************************
    // write response
    // ****************************************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= SCGR_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_dec[2] ? SCGR_RESP_OKAY : SCGR_RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ****************************************************************
    // read path
    // ****************************************************************
    logic rvalid_reg;
    logic arready_reg;
    logic [1:0] rresp_reg;
    logic ar_take;
    logic [2:0] rd_dec;
    logic [7:0] rd_byte;

    // one read in flight: no new address until the data has been taken
    assign ar_take = s_axi_arvalid_i && !rvalid_reg;
    assign rd_dec = decode_addr(s_axi_araddr_i);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
            rresp_reg <= SCGR_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            arready_reg <= 1'b0;
            rresp_reg <= rd_dec[2] ? SCGR_RESP_OKAY : SCGR_RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // ****************************************************************
    // register storage
    // ****************************************************************
    logic [7:0] regs [SCGR_NUM_REGS];

    scgr_reg_store #(
        .NUM_REGS(SCGR_NUM_REGS)
    ) u_store (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(wr_en),
        .wr_slot_i(wr_dec[1:0]),
        .wr_data_i(w_data_reg),
        .rd_en_i(ar_take),
        .rd_hit_i(rd_dec[2]),
        .rd_slot_i(rd_dec[1:0]),
        .rd_data_o(rd_byte),
        .regs_o(regs)
    );

    // ****************************************************************
    // field breakout towards the core
    // ****************************************************************
    // one flop stage so the core sees new settings a cycle after storage;
    // reserved band code 3 is passed on unchanged, the core must cope
    function automatic scgr_chan_cfg_s split_cfg(input logic [7:0] raw);
        scgr_chan_cfg_s cfg;
        cfg.resistance_range = raw[SCGR_RANGE_BIT];
        cfg.frequency_band =
            scgr_band_e'(raw[SCGR_BAND_MSB:SCGR_BAND_LSB]);
        cfg.cycle_count = raw[SCGR_COUNT_MSB:SCGR_COUNT_LSB];
        return cfg;
    endfunction : split_cfg

    scgr_chan_cfg_s chan0_cfg_reg;
    scgr_chan_cfg_s chan1_cfg_reg;
    scgr_chan_cfg_s chan2_cfg_reg;
    logic [1:0] chan0_ftf_reg;
    scgr_tracking_s trk_view;

    assign trk_view = scgr_tracking_s'(regs[SCGR_SLOT_CHAN0_TRK]);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chan0_cfg_reg <= scgr_chan_cfg_s'(SCGR_RST_CHAN_CFG);
            chan1_cfg_reg <= scgr_chan_cfg_s'(SCGR_RST_CHAN_CFG);
            chan2_cfg_reg <= scgr_chan_cfg_s'(SCGR_RST_CHAN_CFG);
        end else begin
            chan0_cfg_reg <= split_cfg(regs[SCGR_SLOT_CHAN0_CFG]);
            chan1_cfg_reg <= split_cfg(regs[SCGR_SLOT_CHAN1_CFG]);
            chan2_cfg_reg <= split_cfg(regs[SCGR_SLOT_CHAN2_CFG]);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chan0_ftf_reg <= SCGR_RST_CHAN0_TRK[SCGR_TRK_FACTOR_MSB:
                                               SCGR_TRK_FACTOR_LSB];
        end else begin
            chan0_ftf_reg <= trk_view.fast_tracking_factor;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o = wready_reg;
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rresp_o = rresp_reg;
    // narrow register data sits in the low byte, upper bits read zero
    assign s_axi_rdata_o = {24'h000000, rd_byte};
    assign chan0_sensor_config_o = chan0_cfg_reg;
    assign chan1_sensor_config_o = chan1_cfg_reg;
    assign chan2_sensor_config_o = chan2_cfg_reg;
    assign chan0_fast_tracking_factor_o = chan0_ftf_reg;

endmodule : scgr_sensor_cfg

/* File: verif/scgr_sensor_cfg_monitor.sv */
// concurrent checks on the ports of the sensor configuration bank
module scgr_sensor_cfg_monitor #(
    parameter int unsigned ADDR_W = 10
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic [2:0] s_axi_awprot_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic [2:0] s_axi_arprot_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire scgr_pkg::scgr_chan_cfg_s chan0_sensor_config_o,
    input wire scgr_pkg::scgr_chan_cfg_s chan1_sensor_config_o,
    input wire scgr_pkg::scgr_chan_cfg_s chan2_sensor_config_o,
    input wire logic [1:0] chan0_fast_tracking_factor_o
);
    import scgr_pkg::*;
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic wr_go;
    // both halves of an idle write offered and taken at one edge
    assign wr_go = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
        s_axi_wready_o && !s_axi_bvalid_o && s_axi_wstrb_i[0];
    cfg_reset_a: assert property ($rose(rst_n_i) |->
        chan0_sensor_config_o == 8'h04 && chan1_sensor_config_o == 8'h04 &&
        chan2_sensor_config_o == 8'h04)
        else $error("channel config not at reset value");
    trk_reset_a: assert property ($rose(rst_n_i) |->
        chan0_fast_tracking_factor_o == 2'h1)
        else $error("tracking factor not at reset value");
    cfg_follow_a: assert property (
        wr_go && s_axi_awaddr_i[ADDR_W-1:2] == 8'h20 |->
        ##3 chan0_sensor_config_o == $past(s_axi_wdata_i[7:0], 3))
        else $error("channel 0 config output did not follow write");
    trk_follow_a: assert property (
        wr_go && s_axi_awaddr_i[ADDR_W-1:2] == 8'h25 |->
        ##3 chan0_fast_tracking_factor_o == $past(s_axi_wdata_i[2:1], 3))
        else $error("tracking factor output did not follow write");
    wr_answer_a: assert property (
        wr_go |-> ##[1:2] s_axi_bvalid_o)
        else $error("write response missing");
    bresp_hold_a: assert property (
        s_axi_bvalid_o && !s_axi_bready_i |=>
        s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped before accepted");
    rd_answer_a: assert property (
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read data not one cycle after address");
    rdata_hold_a: assert property (
        s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o) && !s_axi_arready_o)
        else $error("read data changed before accepted");
    upper_zero_a: assert property (
        s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
        else $error("read data upper bytes not zero");
endmodule : scgr_sensor_cfg_monitor

bind scgr_sensor_cfg scgr_sensor_cfg_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

/* File: verif/scgr_sensor_cfg_test.sv */
// self-checking bench for the sensor channel configuration bank
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module scgr_sensor_cfg_test;
    timeunit 1ns;
    timeprecision 1ps;
    import scgr_pkg::*;
    logic clk, rst_n, aw_v, aw_rdy, w_v, w_rdy, b_v, b_rdy;
    logic ar_v, ar_rdy, r_v, r_rdy;
    logic [9:0] aw_a, ar_a;
    logic [31:0] w_d, r_d;
    logic [3:0] w_s;
    logic [1:0] b_r, r_r, ftf;
    scgr_chan_cfg_s cfg0, cfg1, cfg2;
    logic [9:0] adr [4];
    logic [7:0] rst_v [4];
    logic [7:0] d;
    int miscompares, check_count;
    scgr_sensor_cfg DUT (.core_clk_i(clk), .rst_n_i(rst_n),
        .s_axi_awaddr_i(aw_a), .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(aw_v),
        .s_axi_awready_o(aw_rdy), .s_axi_wdata_i(w_d), .s_axi_wstrb_i(w_s),
        .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_r),
        .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_rdy), .s_axi_araddr_i(ar_a),
        .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(ar_v),
        .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_r),
        .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_rdy),
        .chan0_sensor_config_o(cfg0), .chan1_sensor_config_o(cfg1),
        .chan2_sensor_config_o(cfg2), .chan0_fast_tracking_factor_o(ftf));
    always #5 clk = ~clk;
    // ****************************************************************
    // bus tasks
    // ****************************************************************
    task automatic complete_run();
        if (miscompares == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    task automatic guard(input int n);
        if (n >= 100) begin
            miscompares++;
            complete_run();
        end
    endtask : guard
    // returns at the edge where the signal is sampled high
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (s !== 1'b1 && n < 100);
        if (s !== 1'b1) guard(100);
    endtask : wait_hi
    task automatic wr(input logic [9:0] a, input logic [7:0] dv,
        input logic [3:0] s, input logic [1:0] er, input int st);
        int n;
        @(posedge clk);
        aw_a <= a;
        w_d <= {24'h0, dv};
        w_s <= s;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (aw_rdy) aw_v <= 1'b0;
            if (w_rdy) w_v <= 1'b0;
        end while (((aw_v && !aw_rdy) || (w_v && !w_rdy)) && n < 100);
        guard(n);
        repeat (st) @(posedge clk);
        b_rdy <= 1'b1;
        wait_hi(b_v);
        b_rdy <= 1'b0;
        `CHK("bresp", er, b_r)
    endtask : wr
    task automatic rd(input logic [9:0] a, input logic [7:0] ed,
        input logic [1:0] er, input int st);
        @(posedge clk);
        ar_a <= a;
        ar_v <= 1'b1;
        wait_hi(ar_rdy);
        ar_v <= 1'b0;
        repeat (st) @(posedge clk);
        r_rdy <= 1'b1;
        wait_hi(r_v);
        r_rdy <= 1'b0;
        `CHK("rdata", {24'h0, ed}, r_d)
        `CHK("rresp", er, r_r)
    endtask : rd
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {clk, rst_n, aw_v, w_v, b_rdy, ar_v, r_rdy} = '0;
        {aw_a, ar_a, w_d, w_s} = '0;
        adr = '{{SCGR_IDX_CHAN0_CFG, 2'h0}, {SCGR_IDX_CHAN1_CFG, 2'h0},
            {SCGR_IDX_CHAN2_CFG, 2'h0}, {SCGR_IDX_CHAN0_TRK, 2'h0}};
        rst_v = '{8'h04, 8'h04, 8'h04, 8'hda};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(adr[i], rst_v[i], SCGR_RESP_OKAY, i);
        end
        `CHK("cfg1", 8'h04, cfg1)
        // every band code with both ranges and spread cycle counts
        for (int i = 0; i < 4; i++) begin
            d = {1'(i), 2'(i), 5'(31 - i * 10)};
            wr(adr[0], d, 4'h1, SCGR_RESP_OKAY, i);
            rd(adr[0] | 10'h3, d, SCGR_RESP_OKAY, 0);
            `CHK("range", d[7], cfg0.resistance_range)
            `CHK("band", d[6:5], cfg0.frequency_band)
            `CHK("count", d[4:0], cfg0.cycle_count)
        end
        wr(adr[1], 8'hff, 4'h1, SCGR_RESP_OKAY, 0);
        wr(adr[2], 8'h00, 4'hf, SCGR_RESP_OKAY, 0);
        rd(adr[1], 8'hff, SCGR_RESP_OKAY, 0);
        `CHK("cfg1", 8'hff, cfg1)
        `CHK("cfg2", 8'h00, cfg2)
        `CHK("cfg0", d, cfg0)
        for (int f = 0; f < 4; f++) begin
            wr(adr[3], {5'h1b, 2'(f), 1'b0}, 4'h1, SCGR_RESP_OKAY, 0);
            rd(adr[3], {5'h1b, 2'(f), 1'b0}, SCGR_RESP_OKAY, 1);
            `CHK("ftf", 2'(f), ftf)
        end
        // reserved tracking bits hold whatever is written
        wr(adr[3], 8'h01, 4'h1, SCGR_RESP_OKAY, 0);
        rd(adr[3], 8'h01, SCGR_RESP_OKAY, 0);
        // lane 0 strobe low leaves the register alone
        wr(adr[1], 8'h12, 4'he, SCGR_RESP_OKAY, 0);
        rd(adr[1], 8'hff, SCGR_RESP_OKAY, 0);
        wr(10'h084, 8'h55, 4'h1, SCGR_RESP_SLVERR, 0);
        rd(10'h084, 8'h00, SCGR_RESP_SLVERR, 0);
        rd(10'h3fc, 8'h00, SCGR_RESP_SLVERR, 0);
        rd(adr[2], 8'h00, SCGR_RESP_OKAY, 0);
        // second reset in mid-run restores every register
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(adr[i], rst_v[i], SCGR_RESP_OKAY, 0);
        end
        `CHK("ftf", 2'h1, ftf)
        complete_run();
    end
endmodule : scgr_sensor_cfg_test
